/* rtl/sink_timers_pkg.sv */
// Package: register map, field layout, reset values and carrier types for the sink timers
package sink_timers_pkg;

  // Register byte offsets
  localparam logic [11:0] TRAIN_OPT_OFFSET = 12'h210;
  localparam logic [11:0] CR_TIMEOUT_OFFSET = 12'h21C;
  localparam logic [11:0] IDLE_LIMIT_OFFSET = 12'h220;
  localparam logic [11:0] INT_STATUS_OFFSET = 12'h240;
  localparam logic [11:0] INT_MASK_OFFSET = 12'h244;
  localparam logic [11:0] TRAIN_STATUS_OFFSET = 12'h248;

  // Training-options field positions
  localparam int EQ_OPT_LSB = 10;
  localparam int MAX_PE_LSB = 12;
  localparam int PE_TABLE_LSB = 14;
  localparam int PE_TABLE_ENTRIES = 5;

  // Clock-recovery config field positions
  localparam int CR_LIMIT_W = 20;
  localparam int CR_DISABLE_BIT = 30;

  // Reset values
  localparam logic [31:0] TRAIN_OPT_RESET = 32'h0000_0000;
  localparam logic [19:0] CR_LIMIT_RESET = 20'h01388;
  localparam logic [31:0] IDLE_LIMIT_RESET = 32'h0131_2D00;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  // Interrupt bit positions
  localparam int INT_UNPLUG_BIT = 0;
  localparam int INT_CR_FAIL_BIT = 1;

  // Channel-equalization policy codes
  typedef enum logic [1:0] {
    EQ_STEP = 2'h0,
    EQ_HOLD = 2'h1,
    EQ_NA = 2'h2,
    EQ_TABLE = 2'h3
  } eq_policy_type;

  // Training attempt states, one-hot
  typedef enum logic [2:0] {
    TR_IDLE = 3'h1,
    TR_LOCK = 3'h2,
    TR_EQ = 3'h4
  } train_state_type;

  // Whole block state
  typedef struct packed {
    logic [31:0] train_opt;
    logic [19:0] cr_limit;
    logic cr_disable;
    logic [31:0] idle_limit;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [31:0] idle_count;
    logic [19:0] cr_count;
    train_state_type tr_state;
    logic [2:0] iteration;
    logic [1:0] pe_request;
    logic train_fail;
    logic [31:0] prdata;
    logic pslverr;
    logic pready_r;
    logic [1:0] bs_sync;
    logic [1:0] lock_sync;
  } sink_state_type;

endpackage

/* rtl/sink_training_and_unplug_timers.sv */
// Sink training pre-emphasis policy, clock-recovery lock timer and unplug idle timer
//
// Summary of operation
// - Training-options bits 13:12 hold the maximum pre-emphasis level.
// - Bits 23:14 hold five 2-bit pre-emphasis levels for iterations one to five.
// - Policy 00 steps to maximum, 01 holds maximum, 11 reads the table.
// - Clock-recovery timeout limit is 20 bits at 19:0, reset 20'h1388.
// - The lock timer counts on the register clock, never the link clock.
// - Bit 30 disables the training timeout so expiry never aborts training.
// - Idle period register is 32 bits, reset 0x1312D00, 200 ms at 100 MHz.
// - No blanking-start symbol for the idle period raises the unplug interrupt.
// - The unplug counter runs on the register clock, loaded from the period.
// - Counter reloads on each blanking-start symbol and on reaching terminal count.
`timescale 1ns/1ps
module sink_training_and_unplug_timers
  import sink_timers_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic train_start,
  input wire logic iteration_step,
  input wire logic cr_locked,
  input wire logic train_done,
  input wire logic bs_seen,
  output logic [1:0] pe_request,
  output logic train_fail,
  output logic [2:0] iteration,
  output logic irq
);

  sink_state_type s_r;
  sink_state_type s_nxt;

  // Maps a byte offset to a known register; drives the error answer
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == TRAIN_OPT_OFFSET) || (a == CR_TIMEOUT_OFFSET) ||
                 (a == IDLE_LIMIT_OFFSET) || (a == INT_STATUS_OFFSET) ||
                 (a == INT_MASK_OFFSET) || (a == TRAIN_STATUS_OFFSET);
  endfunction

  // Table entry for a 1-based iteration, last entry beyond five
  function automatic logic [1:0] table_level(input logic [31:0] opt, input logic [2:0] it);
    logic [2:0] idx;
    idx = (it == 3'h0) ? 3'h0 : ((it > 3'h5) ? 3'h4 : 3'(it - 3'h1));
    table_level = opt[PE_TABLE_LSB + 2 * idx +: 2];
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic acc_first;
  logic bs_edge_free;
  logic [1:0] max_pe;
  eq_policy_type eq_opt;

  // One wait state lets registered read data and error stand at the ready edge
  assign acc_first = psel && penable && !s_r.pready_r;
  assign wr_acc = psel && penable && pwrite && s_r.pready_r;
  assign rd_acc = acc_first && !pwrite;
  // Fields decoded from the options register; the free reload source is tied low
  // maximum level field
  assign max_pe = s_r.train_opt[MAX_PE_LSB +: 2];
  assign eq_opt = eq_policy_type'(s_r.train_opt[EQ_OPT_LSB +: 2]);
  assign bs_edge_free = 1'b0;

  // Next-state logic for registers, timers and the training attempt
  always_comb begin
    s_nxt = s_r;
    // Ready and error answer the first access cycle one cycle later
    s_nxt.pready_r = acc_first;
    s_nxt.pslverr = acc_first && !addr_known(paddr);
    // bs_seen and cr_locked pass two flops before use
    s_nxt.bs_sync = {s_r.bs_sync[0], bs_seen};
    s_nxt.lock_sync = {s_r.lock_sync[0], cr_locked};

    // Register writes take effect at the edge where pready is high
    if (wr_acc) begin
      unique case (paddr)
        TRAIN_OPT_OFFSET: s_nxt.train_opt = pwdata;
        CR_TIMEOUT_OFFSET: begin
          s_nxt.cr_limit = pwdata[CR_LIMIT_W-1:0];
          s_nxt.cr_disable = pwdata[CR_DISABLE_BIT];
        end
        IDLE_LIMIT_OFFSET: s_nxt.idle_limit = pwdata;
        INT_MASK_OFFSET: s_nxt.int_mask = pwdata[1:0];
        default: ;
      endcase
    end

    // Read data is registered; a status read clears the sticky bits
    if (rd_acc) begin
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        TRAIN_OPT_OFFSET: s_nxt.prdata = s_r.train_opt;
        CR_TIMEOUT_OFFSET: begin
          s_nxt.prdata[CR_LIMIT_W-1:0] = s_r.cr_limit;
          s_nxt.prdata[CR_DISABLE_BIT] = s_r.cr_disable;
        end
        IDLE_LIMIT_OFFSET: s_nxt.prdata = s_r.idle_limit;
        INT_STATUS_OFFSET: begin
          s_nxt.prdata[1:0] = s_r.int_status;
          s_nxt.int_status = 2'h0;
        end
        INT_MASK_OFFSET: s_nxt.prdata[1:0] = s_r.int_mask;
        TRAIN_STATUS_OFFSET: s_nxt.prdata = {22'h0, s_r.tr_state, s_r.iteration,
                                             s_r.pe_request, s_r.train_fail, s_r.lock_sync[1]};
        default: ;
      endcase
    end

    // Unplug counter counts down on pclk, reloading on symbol or timeout
    // register clock, loaded from period
    // reload on symbol or terminal count
    if (s_r.bs_sync[1] || bs_edge_free) begin
      s_nxt.idle_count = s_r.idle_limit;
    end else if (s_r.idle_count == 32'h0000_0000) begin
      s_nxt.idle_count = s_r.idle_limit;
      // unplug event, set wins over clear
      s_nxt.int_status[INT_UNPLUG_BIT] = 1'b1;
    end else begin
      s_nxt.idle_count = s_r.idle_count - 32'h0000_0001;
    end

    // Training attempt sequencing
    unique case (s_r.tr_state)
      TR_IDLE: begin
        if (train_start) begin
          s_nxt.tr_state = TR_LOCK;
          s_nxt.cr_count = 20'h00000;
          s_nxt.train_fail = 1'b0;
          s_nxt.iteration = 3'h0;
        end
      end
      TR_LOCK: begin
        s_nxt.cr_count = 20'(s_r.cr_count + 20'h00001);
        if (s_r.lock_sync[1]) begin
          // First equalization iteration
          s_nxt.tr_state = TR_EQ;
          s_nxt.iteration = 3'h1;
          s_nxt.pe_request = (eq_opt == EQ_TABLE) ? table_level(s_r.train_opt, 3'h1) :
                             (eq_opt == EQ_HOLD) ? max_pe : 2'h0;
        end else if (!s_r.cr_disable && s_r.cr_count >= s_r.cr_limit) begin
          s_nxt.tr_state = TR_IDLE;
          s_nxt.train_fail = 1'b1;
          s_nxt.int_status[INT_CR_FAIL_BIT] = 1'b1;
        end
      end
      TR_EQ: begin
        if (train_done || train_start) begin
          s_nxt.tr_state = TR_IDLE;
        end else if (iteration_step) begin
          s_nxt.iteration = (s_r.iteration == 3'h7) ? 3'h7 : 3'(s_r.iteration + 3'h1);
          unique case (eq_opt)
            EQ_STEP: s_nxt.pe_request = (s_r.pe_request < max_pe) ?
                                        2'(s_r.pe_request + 2'h1) : max_pe;
            EQ_HOLD: s_nxt.pe_request = max_pe;
            EQ_TABLE: s_nxt.pe_request = table_level(s_r.train_opt,
                                          (s_r.iteration == 3'h7) ? 3'h7 :
                                          3'(s_r.iteration + 3'h1));
            EQ_NA: s_nxt.pe_request = s_r.pe_request; // Unused code holds level
          endcase
        end
      end
      default: s_nxt.tr_state = TR_IDLE;
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{train_opt: TRAIN_OPT_RESET, cr_limit: CR_LIMIT_RESET, cr_disable: 1'b0,
               idle_limit: IDLE_LIMIT_RESET, int_status: 2'h0, int_mask: INT_MASK_RESET,
               idle_count: IDLE_LIMIT_RESET, cr_count: 20'h00000, tr_state: TR_IDLE,
               iteration: 3'h0, pe_request: 2'h0, train_fail: 1'b0,
               prdata: 32'h0000_0000, pslverr: 1'b0, pready_r: 1'b0, bs_sync: 2'h0,
               lock_sync: 2'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register; irq is the OR of status bits gated by the mask
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign pready = s_r.pready_r;
  assign pe_request = s_r.pe_request;
  assign train_fail = s_r.train_fail;
  assign iteration = s_r.iteration;
  assign irq = |(s_r.int_status & s_r.int_mask);

endmodule // sink_training_and_unplug_timers

/* sim/link_source_model.sv */
// Link source model: blanking-start pulses and a late clock-recovery lock
`timescale 1ns/1ps
module link_source_model (
  input wire logic pclk,
  input wire logic bs_on,
  input wire logic lock_on,
  output logic bs_seen,
  output logic cr_locked
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] lk = 3'h0;
  // Stream phase counter and lock delay line; a slow lock shows the sync path
  always_ff @(posedge pclk) begin
    cnt <= cnt + 3'h1;
    lk <= {lk[1:0], lock_on};
  end
  assign bs_seen = bs_on && (cnt == 3'h0);
  assign cr_locked = lk[2];
endmodule // link_source_model

/* sim/sink_timers_monitor.sv */
// Checker: port timing of the sink training and unplug timers
`timescale 1ns/1ps
module sink_timers_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic train_start,
  input wire logic iteration_step,
  input wire logic train_done,
  input wire logic train_fail,
  input wire logic [1:0] pe_request,
  input wire logic [2:0] iteration,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  slverr_pulse_a: assert property (pslverr |=> !pslverr) else $error("slverr too long");
  slverr_cause_a: assert property (pslverr |-> $past(psel && penable)) else $error("slverr no access");
  fail_hold_a: assert property (train_fail && !train_start |=> train_fail) else $error("fail dropped");
  fail_idle_a: assert property (train_fail |-> iteration == 3'h0) else $error("fail not idle");
  step_adv_a: assert property (iteration_step && iteration inside {[1:6]} && !train_start && !train_done
    |=> iteration == $past(iteration) + 3'h1) else $error("step missed");
  iter_hold_a: assert property (iteration != 3'h0 && !iteration_step && !train_start && !train_done
    |=> $stable(iteration)) else $error("iteration moved");
  pe_hold_a: assert property (iteration != 3'h0 && !iteration_step && !train_start && !train_done
    |=> $stable(pe_request)) else $error("level moved");
  cover property ($rose(train_fail));
  cover property ($rose(irq));
  cover property (iteration == 3'h6);
endmodule // sink_timers_monitor
bind sink_training_and_unplug_timers sink_timers_monitor sink_timers_monitor_i (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .train_start, .iteration_step, .train_done, .train_fail,
  .pe_request, .iteration, .irq);

/* sim/tb.sv */
// Testbench: registers, pre-emphasis policies, lock timeout and unplug interrupt
`timescale 1ns/1ps
module tb;
  import sink_timers_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, irq, train_fail, cr_locked, bs_seen;
  logic train_start = 0, iteration_step = 0, train_done = 0, bs_on = 0, lock_on = 0;
  logic [1:0] pe_request, ex;
  logic [2:0] iteration;
  logic [1:0] pol [3] = '{2'h0, 2'h1, 2'h3};
  logic [9:0] tv;
  int num_errors = 0, n_checks = 0, k;
  sink_training_and_unplug_timers sink_training_and_unplug_timers_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .train_start, .iteration_step,
    .cr_locked, .train_done, .bs_seen, .pe_request, .train_fail, .iteration, .irq);
  link_source_model link_source_model_i (.pclk, .bs_on, .lock_on, .bs_seen, .cr_locked);
  // Free-running register clock
  initial forever #10 pclk = ~pclk;
  task chk(string n, logic [31:0] e, logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  // Read data and error are taken at the edge where pready is sampled high
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    sv = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // Pulse one control input: 0 start, 1 step, 2 done
  task pulse(int w);
    case (w)
      0: train_start <= 1;
      1: iteration_step <= 1;
      default: train_done <= 1;
    endcase
    @(posedge pclk);
    train_start <= 0; iteration_step <= 0; train_done <= 0;
    cyc(1);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #1000000 num_errors++;
    summarize;
  end
  initial begin
    cyc(6); presetn <= 1; cyc(1);
    apb(0, CR_TIMEOUT_OFFSET, 0); chk("cr reset", 32'h1388, rd_v);
    apb(0, IDLE_LIMIT_OFFSET, 0); chk("idle reset", 32'h0131_2D00, rd_v);
    apb(0, 12'h300, 0); chk("unmapped", 0, rd_v); chk("slverr", 1, sv);
    apb(1, CR_TIMEOUT_OFFSET, 32'hFFFF_FFFF); apb(0, CR_TIMEOUT_OFFSET, 0);
    chk("cr fields", 32'h400F_FFFF, rd_v);
    apb(1, CR_TIMEOUT_OFFSET, 32'h14); pulse(0); cyc(30);
    chk("lock timeout", 1, train_fail);
    apb(0, INT_STATUS_OFFSET, 0); chk("fail status", 2, rd_v); chk("masked irq", 0, irq);
    apb(0, INT_STATUS_OFFSET, 0); chk("status cleared", 0, rd_v);
    apb(1, CR_TIMEOUT_OFFSET, 32'h4000_0014); pulse(0); cyc(40);
    chk("timeout off", 0, train_fail);
    $display("lock timeout test done");
    lock_on <= 1; cyc(8); pulse(2);
    foreach (pol[j]) begin
      apb(1, TRAIN_OPT_OFFSET, {8'h00, 10'h18D, 2'h2, pol[j], 10'h000});
      pulse(0); cyc(8);
      for (int i = 1; i <= 6; i++) begin
        k = i - 1;
        tv = 10'h18D >> (2 * ((i > 5) ? 4 : k));
        ex = (pol[j] == 2'h3) ? tv[1:0] : (pol[j] == 2'h1 || k > 2) ? 2'h2 : k[1:0];
        chk("iteration", i, iteration);
        chk("pe level", ex, pe_request);
        pulse(1);
      end
      pulse(2);
      $display("policy %0d test done", pol[j]);
    end
    apb(1, INT_MASK_OFFSET, 1); apb(1, IDLE_LIMIT_OFFSET, 20); bs_on <= 1; cyc(60);
    chk("no unplug", 0, irq);
    bs_on <= 0; cyc(30); chk("unplug irq", 1, irq);
    apb(0, INT_STATUS_OFFSET, 0); chk("unplug status", 1, rd_v); cyc(2);
    chk("irq cleared", 0, irq);
    cyc(25); chk("reload expiry", 1, irq);
    apb(1, INT_MASK_OFFSET, 0); chk("irq masked", 0, irq);
    $display("unplug test done");
    summarize;
  end
endmodule // tb
